//--- core/tacc_core.sv
// Accumulators, carry, counter, trap and interrupt sequencing
`timescale 1ns/100ps
module tacc_core import tacc_pkg::*; #(
  parameter int MAX_IND = MAX_INDIRECT
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        exec_valid,
  input  wire logic [15:0] exec_instr,
  input  wire logic [14:0] fetch_addr,
  input  wire logic        fetch_boundary,
  input  wire logic        halted,
  input  wire logic        peripheral_request_n,
  input  wire logic        rtc_request_set,
  input  wire logic        ovf_request_set,
  input  wire logic        rtc_enable,
  input  wire logic        int_enable_set,
  output logic             busy,
  output logic             mem_req,
  output logic             mem_write,
  output logic      [14:0] mem_addr,
  output logic      [15:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  output logic      [14:0] pc,
  output logic             carry,
  output logic             int_enable,
  output logic             rtc_request,
  output logic             ovf_request,
  output logic      [15:0] acc0,
  output logic      [15:0] acc1,
  output logic      [15:0] acc2,
  output logic      [15:0] acc3,
  output logic             ind_error
);
  initial begin
    if (MAX_IND < 1 || MAX_IND > 255) $error("MAX_IND out of range");
  end

  // *********************************************
  // Accumulator selection
  // *********************************************
  logic [15:0] acc [4];
  wire [1:0] source_acc_field = exec_instr[SRC_HI -: 2];
  wire [1:0] dest_acc_field = exec_instr[DST_HI -: 2];
  wire [15:0] src_val = acc[source_acc_field];
  wire [15:0] dst_val = acc[dest_acc_field];
  wire [15:0] shifted;
  wire        carry_out;
  wire        skip;
  tacc_alu u_alu (
    .instr     (exec_instr),
    .src_val   (src_val),
    .dst_val   (dst_val),
    .carry     (carry),
    .shifted   (shifted),
    .carry_out (carry_out),
    .skip      (skip)
  );
  wire no_load = exec_instr[NOLOAD_POS];
  wire is_trap = no_load && (exec_instr[SKP_HI -: 3] == 3'h0);
  assign acc0 = acc[0];
  assign acc1 = acc[1];
  assign acc2 = acc[2];
  assign acc3 = acc[3];

  // *********************************************
  // Interrupt arbitration
  // *********************************************
  // Request taken only at boundaries or while halted, so a peripheral must hold it
  logic ext_s1;
  logic ext_s2;
  wire ovf_pend = ovf_request;
  wire rtc_pend = rtc_request && rtc_enable;
  wire ext_pend = ~ext_s2;
  wire int_window = (fetch_boundary || halted) && int_enable;
  wire int_take = int_window && (ovf_pend || rtc_pend || ext_pend);
  wire [14:0] int_vector = ovf_pend ? LOC_VEC_OVF :
                           rtc_pend ? LOC_VEC_RTC :
                           LOC_VEC_EXT;

  // *********************************************
  // Sequencer
  // *********************************************
  tacc_state_type state;
  logic [14:0] vec_addr;
  logic [14:0] save_word;
  logic [7:0]  ind_count;
  wire idle = (state == TACC_IDLE);
  wire start_trap = idle && exec_valid && is_trap;
  wire start_int = idle && !exec_valid && int_take;
  wire do_alu = idle && exec_valid && !is_trap;
  wire clr_rtc = start_int && !ovf_pend && rtc_pend;
  wire clr_ovf = start_int && ovf_pend;
  assign busy = !idle;
  assign mem_req = (state == TACC_SAVE) || (state == TACC_VREAD) ||
                   (state == TACC_IND);
  assign mem_write = (state == TACC_SAVE);

  always_ff @(posedge clk_sys) begin
    ext_s1 <= peripheral_request_n;
    ext_s2 <= ext_s1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= TACC_IDLE;
      mem_addr <= 15'h0000;
      mem_wdata <= 16'h0000;
      vec_addr <= 15'h0000;
      save_word <= 15'h0000;
      ind_count <= 8'h00;
      ind_error <= 1'b0;
    end else begin
      unique case (state)
        TACC_IDLE: begin
          if (start_trap) begin
            state <= TACC_SAVE;
            mem_addr <= LOC_TRAP_SAVE;
            mem_wdata <= {1'b0, fetch_addr};
            vec_addr <= LOC_TRAP_VEC;
          end else if (start_int) begin
            state <= TACC_SAVE;
            mem_addr <= LOC_SAVE_PC;
            mem_wdata <= {1'b0, pc};
            vec_addr <= int_vector;
          end
        end
        TACC_SAVE: begin
          if (mem_ack) begin
            state <= TACC_VREAD;
            mem_addr <= vec_addr;
            ind_count <= 8'h00;
          end
        end
        TACC_VREAD, TACC_IND: begin
          if (mem_ack) begin
            save_word <= mem_rdata[14:0];
            if (mem_rdata[15] && ind_count < 8'(MAX_IND)) begin
              // Indirect chain is bounded so a loop cannot hang
              state <= TACC_IND;
              mem_addr <= mem_rdata[14:0];
              ind_count <= ind_count + 8'h01;
            end else begin
              ind_error <= mem_rdata[15];
              state <= TACC_DONE;
            end
          end
        end
        TACC_DONE: begin
          state <= TACC_IDLE;
        end
        // Three codes of the state word are unused; recover to idle
        default: begin
          state <= TACC_IDLE;
        end
      endcase
    end
  end

  // *********************************************
  // Architectural state
  // *********************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pc <= 15'h0000;
      carry <= 1'b0;
      acc <= '{default: 16'h0000};
    end else begin
      if (do_alu) begin
        pc <= skip ? pc + 15'h0002 : pc + 15'h0001;
        if (!no_load) begin
          acc[dest_acc_field] <= shifted;
          carry <= carry_out;
        end
      end else if (state == TACC_DONE) begin
        pc <= save_word;
      end
    end
  end

  // Request set wins over its clear in the same cycle; taking an interrupt wins over int_enable_set
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_enable <= IEN_RESET;
      rtc_request <= 1'b0;
      ovf_request <= 1'b0;
    end else begin
      if (start_int) begin
        int_enable <= 1'b0;
      end else if (int_enable_set) begin
        int_enable <= 1'b1;
      end
      if (rtc_request_set) begin
        rtc_request <= 1'b1;
      end else if (clr_rtc) begin
        rtc_request <= 1'b0;
      end
      if (ovf_request_set) begin
        ovf_request <= 1'b1;
      end else if (clr_ovf) begin
        ovf_request <= 1'b0;
      end
    end
  end
endmodule

//--- core/tacc_pkg.sv
// Constants and types shared by the four-accumulator execution datapath
package tacc_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 15;
  // Field positions, bit 15 is the most significant instruction bit
  localparam int SRC_HI = 14;
  localparam int DST_HI = 12;
  localparam int OP_HI = 10;
  localparam int SH_HI = 7;
  localparam int CRY_HI = 5;
  localparam int NOLOAD_POS = 3;
  localparam int SKP_HI = 2;
  localparam logic [2:0] OP_INV = 3'h0;
  localparam logic [2:0] OP_NEG = 3'h1;
  localparam logic [2:0] OP_MOV = 3'h2;
  localparam logic [2:0] OP_INC = 3'h3;
  localparam logic [2:0] OP_ISUM = 3'h4;
  localparam logic [2:0] OP_DIFF = 3'h5;
  localparam logic [2:0] OP_SUM = 3'h6;
  localparam logic [2:0] OP_AND = 3'h7;
  localparam logic [1:0] SH_NONE = 2'h0;
  localparam logic [1:0] SH_LEFT = 2'h1;
  localparam logic [1:0] SH_RIGHT = 2'h2;
  localparam logic [1:0] SH_SWAP = 2'h3;
  localparam logic [14:0] LOC_SAVE_PC = 15'h0000;
  localparam logic [14:0] LOC_VEC_EXT = 15'h0001;
  localparam logic [14:0] LOC_VEC_RTC = 15'h0002;
  localparam logic [14:0] LOC_VEC_OVF = 15'h0003;
  localparam logic [14:0] LOC_TRAP_SAVE = 15'h0026;
  localparam logic [14:0] LOC_TRAP_VEC = 15'h0027;
  localparam logic IEN_RESET = 1'b0;
  localparam int MAX_INDIRECT = 255;
  typedef enum logic [2:0] {
    TACC_IDLE, TACC_SAVE, TACC_VREAD, TACC_IND, TACC_DONE
  } tacc_state_type;
endpackage

//--- core/tacc_alu.sv
// Combinational operation, shift and skip logic of one instruction
`timescale 1ns/100ps
module tacc_alu import tacc_pkg::*; (
  input  wire logic [15:0] instr,
  input  wire logic [15:0] src_val,
  input  wire logic [15:0] dst_val,
  input  wire logic        carry,
  output logic      [15:0] shifted,
  output logic             carry_out,
  output logic             skip
);
  // *********************************************
  // Field decode
  // *********************************************
  wire [2:0] op_field = instr[OP_HI -: 3];
  wire [1:0] rotate_select_field = instr[SH_HI -: 2];
  wire [1:0] cry_field = instr[CRY_HI -: 2];
  wire [2:0] skip_select_field = instr[SKP_HI -: 3];
  wire       base_carry = (cry_field == 2'h0) ? carry :
                          (cry_field == 2'h1) ? 1'b0 :
                          (cry_field == 2'h2) ? 1'b1 : ~carry;

  // *********************************************
  // Arithmetic
  // *********************************************
  wire [16:0] sum_full = {1'b0, src_val} + {1'b0, dst_val};
  wire [15:0] neg_val = 16'h0000 - src_val;
  wire [15:0] inc_val = src_val + 16'h0001;
  logic [15:0] al_result;
  logic        flip;
  always_comb begin
    al_result = src_val;
    flip = 1'b0;
    unique case (op_field)
      OP_INV: begin
        al_result = ~src_val;
      end
      OP_NEG: begin
        al_result = neg_val;
        flip = (neg_val == 16'h0000);
      end
      OP_MOV: begin
        al_result = src_val;
      end
      OP_INC: begin
        al_result = inc_val;
        flip = (inc_val == 16'h0000);
      end
      OP_ISUM: begin
        al_result = ~src_val + dst_val;
        flip = (dst_val > src_val);
      end
      OP_DIFF: begin
        al_result = dst_val - src_val;
        flip = (dst_val >= src_val);
      end
      OP_SUM: begin
        al_result = sum_full[15:0];
        flip = sum_full[16];
      end
      OP_AND: begin
        al_result = src_val & dst_val;
      end
    endcase
  end
  wire carry_in = base_carry ^ flip;

  // *********************************************
  // Shift and skip
  // *********************************************
  always_comb begin
    shifted = al_result;
    carry_out = carry_in;
    unique case (rotate_select_field)
      SH_NONE: begin
        shifted = al_result;
      end
      SH_LEFT: begin
        {carry_out, shifted} = {al_result, carry_in};
      end
      SH_RIGHT: begin
        {shifted, carry_out} = {carry_in, al_result};
      end
      SH_SWAP: begin
        shifted = {al_result[7:0], al_result[15:8]};
      end
    endcase
  end
  wire r_zero = (shifted == 16'h0000);
  always_comb begin
    skip = 1'b0;
    unique case (skip_select_field)
      3'h0: skip = 1'b0;
      3'h1: skip = 1'b1;
      3'h2: skip = ~carry_out;
      3'h3: skip = carry_out;
      3'h4: skip = r_zero;
      3'h5: skip = ~r_zero;
      3'h6: skip = ~carry_out | r_zero;
      3'h7: skip = carry_out & ~r_zero;
    endcase
  end
endmodule

//--- bench/tacc_core_props.sv
// Checker of trap, interrupt, load and skip behaviour at the core ports
`timescale 1ns/100ps
module tacc_core_props #(
  parameter int MAX_IND = 255
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        exec_valid,
  input wire logic [15:0] exec_instr,
  input wire logic [14:0] fetch_addr,
  input wire logic        fetch_boundary,
  input wire logic        halted,
  input wire logic        ovf_request_set,
  input wire logic        rtc_enable,
  input wire logic        busy,
  input wire logic        mem_req,
  input wire logic        mem_write,
  input wire logic [14:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [14:0] pc,
  input wire logic        carry,
  input wire logic        int_enable,
  input wire logic        rtc_request,
  input wire logic        ovf_request,
  input wire logic [15:0] acc0,
  input wire logic [15:0] acc1,
  input wire logic [15:0] acc2,
  input wire logic [15:0] acc3
);
  // ****
  // What the core takes at this edge
  // ****
  // External request is synchronised inside, so only internal ones count
  wire go   = !busy && exec_valid;
  wire trap = go && exec_instr[3] && exec_instr[2:0] == 3'h0;
  wire alu  = go && !trap;
  wire pend = ovf_request || (rtc_enable && rtc_request);
  wire at   = fetch_boundary || halted;
  wire take = !busy && !exec_valid && at && int_enable && pend;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_TRAP_SAVE: assert property (trap |=> mem_req && mem_write &&
    mem_addr == 15'h0026 && mem_wdata == {1'b0, $past(fetch_addr)})
    else $error("trap save word wrong");
  AST_NO_LOAD: assert property (alu && exec_instr[3] |=>
    $stable(acc0) && $stable(acc1) && $stable(acc2) && $stable(acc3)
    && $stable(carry)) else $error("no-load instruction loaded");
  AST_SKIP_NEVER: assert property (alu && exec_instr[2:0] == 3'h0
    |=> pc == $past(pc) + 15'h1) else $error("pc not advanced by one");
  AST_SKIP_ALWAYS: assert property (alu && exec_instr[2:0] == 3'h1
    |=> pc == $past(pc) + 15'h2) else $error("pc not advanced by two");
  AST_INT_ENABLE: assert property (take |=> !int_enable && busy)
    else $error("interrupt did not clear enable");
  AST_INT_SAVE: assert property (take |-> ##[1:2] mem_req &&
    mem_write && mem_addr == 15'h0000) else $error("pc not saved at 0");
  AST_OVF_CLEAR: assert property (take && ovf_request &&
    !ovf_request_set |=> !ovf_request) else $error("overflow not cleared");
  AST_PRIORITY: assert property (take && ovf_request |->
    ##[1:40] mem_req && !mem_write && mem_addr == 15'h0003)
    else $error("overflow vector not read first");
  AST_GATE: assert property (!busy && !exec_valid && !int_enable
    |=> !busy) else $error("interrupt taken while disabled");
endmodule

//--- bench/tacc_mem_model.sv
// Memory partner with a settable answer delay
`timescale 1ns/100ps
module tacc_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [3:0]  wait_cycles,
  input  wire logic        mem_req,
  input  wire logic        mem_write,
  input  wire logic [14:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic             mem_ack,
  output logic      [15:0] mem_rdata
);
  // ****
  // Small store, one ack pulse after wait_cycles
  // ****
  logic [15:0] mem [64];
  logic [3:0]  cnt;
  // Data outside the ack cycle flips, so a late sample shows up
  always_ff @(posedge clk_sys) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (rst || !mem_req || mem_ack) begin
      cnt <= 4'h0;
    end else if (cnt != wait_cycles) begin
      cnt <= cnt + 4'h1;
    end else begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[5:0]];
      if (mem_write) begin
        mem[mem_addr[5:0]] <= mem_wdata;
      end
    end
  end
endmodule

//--- bench/tacc_core_tb.sv
// Self-checking bench of the four-accumulator core
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  n_fail++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module tacc_core_tb;
  // ****
  // Signals, instances and reference
  // ****
  localparam int MAX_IND = 4;
  logic        clk_sys, rst, exec_valid, fetch_boundary, halted, m_c;
  logic        peripheral_request_n, rtc_request_set, ovf_request_set;
  logic        int_enable_set, mem_ack, busy, mem_req, mem_write, carry;
  logic        int_enable, rtc_request, ovf_request, ind_error, rtc_enable;
  logic [15:0] exec_instr, mem_wdata, mem_rdata, acc0, acc1, acc2, acc3;
  logic [14:0] fetch_addr, mem_addr, pc, m_pc;
  logic [15:0] m_acc [4];
  logic [3:0]  wait_cycles;
  int          n_fail, check_count;
  tacc_core #(.MAX_IND(MAX_IND)) dut (.clk_sys, .rst, .exec_valid,
    .exec_instr, .fetch_addr, .fetch_boundary, .halted,
    .peripheral_request_n, .rtc_request_set, .ovf_request_set, .rtc_enable,
    .int_enable_set, .busy, .mem_req, .mem_write, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata, .pc, .carry, .int_enable, .rtc_request,
    .ovf_request, .acc0, .acc1, .acc2, .acc3, .ind_error);
  tacc_mem_model mdl (.clk_sys, .rst, .wait_cycles, .mem_req, .mem_write,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
  // Returns {skip, carry out, shifted result}
  function automatic logic [17:0] ref_alu(input logic [15:0] i, s, d,
                                          input logic c);
    logic        b;
    logic        z;
    logic [16:0] t;
    logic [7:0]  v;
    b = i[5:4] == 2'h0 ? c : i[5:4] == 2'h1 ? 1'b0 : i[5:4] == 2'h2 ? 1'b1 : ~c;
    case (i[10:8])
      3'h0: t = {b, ~s};
      3'h1: t = {b ^ (s == 16'h0), -s};
      3'h2: t = {b, s};
      3'h3: t = {b ^ (s == 16'hffff), s + 16'h1};
      3'h4: t = {b ^ (d > s), ~s + d};
      3'h5: t = {b ^ (d >= s), d - s};
      3'h6: t = {1'b0, s} + {1'b0, d} ^ {b, 16'h0};
      default: t = {b, s & d};
    endcase
    case (i[7:6])
      2'h1: t = {t[15:0], t[16]};
      2'h2: t = {t[0], t[16:1]};
      2'h3: t = {t[16], t[7:0], t[15:8]};
      default: ;
    endcase
    z = t[15:0] == 16'h0;
    v = {t[16] & ~z, ~t[16] | z, ~z, z, t[16], ~t[16], 2'h2};
    return {v[i[2:0]], t};
  endfunction
  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 200) begin
      tick();
      n++;
    end
    `CHK("busy", lvl, busy);
  endtask
  task automatic run_alu(input logic [15:0] ins);
    logic [17:0] r;
    r = ref_alu(ins, m_acc[ins[14:13]], m_acc[ins[12:11]], m_c);
    exec_valid = 1'b1;
    exec_instr = ins;
    tick();
    if (!ins[3]) begin
      m_acc[ins[12:11]] = r[15:0];
      m_c = r[16];
    end
    m_pc = m_pc + (r[17] ? 15'h2 : 15'h1);
    `CHK("acc0", m_acc[0], acc0);
    `CHK("acc1", m_acc[1], acc1);
    `CHK("acc2", m_acc[2], acc2);
    `CHK("acc3", m_acc[3], acc3);
    `CHK("carry", m_c, carry);
    `CHK("pc", m_pc, pc);
  endtask
  task automatic run_int(input logic [14:0] exp_pc);
    logic [14:0] old;
    old = pc;
    int_enable_set = 1'b1;
    tick();
    int_enable_set = 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    `CHK("pc", exp_pc, pc);
    `CHK("save", {1'b0, old}, mdl.mem[0]);
    `CHK("ien", 1'b0, int_enable);
  endtask
  // ****
  // Clock, watchdog and test sequence
  // ****
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    #1000000;
    n_fail++;
    complete_run();
  end
  initial begin
    {rst, exec_valid, fetch_boundary, halted, rtc_enable} = 5'h11;
    {rtc_request_set, ovf_request_set, int_enable_set, m_c} = 4'h0;
    {exec_instr, fetch_addr, m_pc} = 46'h0;
    {peripheral_request_n, wait_cycles} = 5'h13;
    m_acc = '{default: 16'h0};
    mdl.mem[39] = 16'h8030;
    mdl.mem[48] = 16'h8031;
    mdl.mem[49] = 16'h0123;
    {mdl.mem[1], mdl.mem[2], mdl.mem[3]} = 48'h0100_8010_0300;
    mdl.mem[16] = 16'h0200;
    repeat (16) tick();
    rst = 1'b0;
    for (int i = 0; i < 256; i++) begin
      run_alu({1'b1, i[1:0] ^ i[7:6], i[5:4], i[2:0], i[4:3], i[6:5], i[7],
               i[7:5]});
    end
    exec_instr = 16'h8008;
    fetch_addr = 15'h1234;
    tick();
    exec_valid = 1'b0;
    wait_busy(1'b0);
    `CHK("trap pc", 15'h0123, pc);
    `CHK("trap save", 16'h1234, mdl.mem[38]);
    `CHK("ind err", 1'b0, ind_error);
    `CHK("acc3", m_acc[3], acc3);
    {rtc_request_set, ovf_request_set, fetch_boundary, wait_cycles} = 7'h70;
    tick();
    {rtc_request_set, ovf_request_set} = 2'h0;
    run_int(15'h0300);
    `CHK("ovf req", 1'b0, ovf_request);
    `CHK("rtc req", 1'b1, rtc_request);
    run_int(15'h0200);
    `CHK("rtc req", 1'b0, rtc_request);
    {fetch_boundary, halted, peripheral_request_n} = 3'h2;
    repeat (3) tick();
    run_int(15'h0100);
    peripheral_request_n = 1'b1;
    complete_run();
  end
endmodule
bind tacc_core tacc_core_props #(.MAX_IND(MAX_IND)) u_props (.clk_sys, .rst,
  .exec_valid, .exec_instr, .fetch_addr, .fetch_boundary, .halted,
  .ovf_request_set, .rtc_enable, .busy, .mem_req, .mem_write, .mem_addr,
  .mem_wdata, .pc, .carry, .int_enable, .rtc_request, .ovf_request, .acc0,
  .acc1, .acc2, .acc3);
